/* File: design/field_dir_latch.sv */
// rotating-field direction taken from the override entry at controller restart
`timescale 1ns/1ns
module field_dir_latch
    import param_store_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       restart,
    input  wire logic [7:0] override_value,
    input  wire logic       default_invert,
    output logic            field_invert
);
    logic field_invert_d;
    logic field_invert_q;

    // the applied direction moves only on restart, never on a plain write
    always_comb begin
        field_invert_d = field_invert_q;
        if (restart) begin
            unique case (override_value)
                FIELD_NORMAL: field_invert_d = 1'b0;
                FIELD_INVERT: field_invert_d = 1'b1;
                default:      field_invert_d = default_invert;
            endcase
        end
    end

    // reset shows a non-inverted field until the first restart samples the entry
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            field_invert_q <= 1'b0;
        end else begin
            field_invert_q <= field_invert_d;
        end
    end

    assign field_invert = field_invert_q;
endmodule

/* File: design/motor_controller_param_store.sv */
// parameter dictionary for the motor controller: flags and loop parameter arrays
`timescale 1ns/1ns
module motor_controller_param_store
    import param_store_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [15:0] index,
    input  wire logic [7:0]  subindex,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             ack,
    output logic             err,
    input  wire logic        restart,
    input  wire logic        default_invert,
    input  wire logic        setup_start,
    input  wire logic        detect_done,
    input  wire logic        detected_bldc,
    input  wire logic [31:0] stepper_torque_kp,
    input  wire logic [31:0] stepper_torque_ti,
    input  wire logic [31:0] bldc_torque_kp,
    input  wire logic [31:0] bldc_torque_ti,
    output logic             field_invert,
    output logic             split_params,
    output logic             setup_busy,
    output logic             setup_done,
    output logic [1:0]       motor_kind,
    output logic [31:0]      torque_kp,
    output logic [31:0]      torque_ti,
    output logic [31:0]      flux_kp,
    output logic [31:0]      flux_ti,
    output logic [31:0]      vel_kp,
    output logic [31:0]      vel_ti,
    output logic [31:0]      pos_kp,
    output logic [31:0]      pos_ti
);
    localparam int NWORDS = 8;
    localparam logic [31:0] PRESETS [NWORDS] = '{
        TORQUE_KP_RESET, TORQUE_TI_RESET, FLUX_KP_RESET, FLUX_TI_RESET,
        VEL_KP_RESET, VEL_TI_RESET, POS_KP_RESET, POS_TI_RESET
    };

    logic [31:0] word_val [NWORDS];
    logic [NWORDS-1:0] word_wr;
    logic              load_en;
    logic [31:0]       load_kp;
    logic [31:0]       load_ti;

    logic [7:0]  reserved_d,  reserved_q;
    logic [7:0]  field_ovr_d, field_ovr_q;
    logic [7:0]  autosrc_d,   autosrc_q;
    logic [7:0]  split_d,     split_q;
    logic [31:0] rdata_d,     rdata_q;
    logic        ack_d,       ack_q;
    logic        err_d,       err_q;
    logic        hit;
    logic [31:0] rd_mux;

    setup_state_t state_d, state_q;
    motor_kind_t  kind_d,  kind_q;
    logic         done_d,  done_q;
    logic         busy_d,  busy_q;
    logic         split_params_d, split_params_q;

    // loop parameter words: torque kp/ti, flux kp/ti, velocity kp/ti, position kp/ti
    for (genvar g = 0; g < NWORDS; g++) begin : g_word
        param_word #(
            .PRESET (PRESETS[g])
        ) u_word (
            .sys_clk   (sys_clk),
            .nrst      (nrst),
            .wr_en     (word_wr[g]),
            .wr_data   (wdata),
            .load_en   (load_en && (g < 4)),
            .load_data ((g % 2 == 0) ? load_kp : load_ti),
            .value     (word_val[g])
        );
    end

    field_dir_latch u_field (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .restart        (restart),
        .override_value (field_ovr_q),
        .default_invert (default_invert),
        .field_invert   (field_invert)
    );

    // address decode and read mux
    always_comb begin
        word_wr     = '0;
        hit         = 1'b1;
        rd_mux      = 32'h00000000;
        reserved_d  = reserved_q;
        field_ovr_d = field_ovr_q;
        autosrc_d   = autosrc_q;
        split_d     = split_q;
        unique case (index)
            IDX_DRIVE_FLAGS: begin
                unique case (subindex)
                    SUB_COUNT:    rd_mux = {24'h000000, DRIVE_FLAGS_COUNT};
                    SUB_RESERVED: rd_mux = {{24{reserved_q[7]}}, reserved_q};
                    SUB_FIELD:    rd_mux = {{24{field_ovr_q[7]}}, field_ovr_q};
                    SUB_AUTOSRC:  rd_mux = {{24{autosrc_q[7]}}, autosrc_q};
                    SUB_SPLIT:    rd_mux = {{24{split_q[7]}}, split_q};
                    default:      hit = 1'b0;
                endcase
                if (req && wr && hit) begin
                    unique case (subindex)
                        SUB_RESERVED: reserved_d  = wdata[7:0];
                        SUB_FIELD:    field_ovr_d = wdata[7:0];
                        SUB_AUTOSRC:  autosrc_d   = wdata[7:0];
                        SUB_SPLIT:    split_d     = wdata[7:0];
                        default:      ;
                    endcase
                end
            end
            IDX_CURRENT: begin
                unique case (subindex)
                    SUB_COUNT:  rd_mux = {24'h000000, CURRENT_COUNT};
                    SUB_ENTRY1: rd_mux = word_val[0];
                    SUB_ENTRY2: rd_mux = word_val[1];
                    SUB_ENTRY3: rd_mux = word_val[2];
                    SUB_ENTRY4: rd_mux = word_val[3];
                    default:    hit = 1'b0;
                endcase
                if (req && wr && hit && subindex != SUB_COUNT) begin
                    word_wr[subindex[2:0] - 3'd1] = 1'b1;
                end
            end
            IDX_VELOCITY, IDX_POSITION: begin
                unique case (subindex)
                    SUB_COUNT:  rd_mux = {24'h000000, (index == IDX_VELOCITY) ? VELOCITY_COUNT : POSITION_COUNT};
                    SUB_ENTRY1: rd_mux = word_val[(index == IDX_VELOCITY) ? 4 : 6];
                    SUB_ENTRY2: rd_mux = word_val[(index == IDX_VELOCITY) ? 5 : 7];
                    default:    hit = 1'b0;
                endcase
                if (req && wr && hit && subindex != SUB_COUNT) begin
                    // words 4/5 are velocity, 6/7 position
                    word_wr[{1'b1, index == IDX_POSITION, subindex[1]}] = 1'b1;
                end
            end
            default: hit = 1'b0;
        endcase
        ack_d   = req;
        err_d   = req && !hit;
        rdata_d = (req && !wr && hit) ? rd_mux : 32'h00000000;
        split_params_d = (split_d != 8'h00);
    end

    // automatic setup: source zero detects the motor and loads its current preset set,
    // source one keeps the stored entries as they are
    always_comb begin
        state_d = state_q;
        kind_d  = kind_q;
        // setup_done is a one-cycle pulse, so it defaults low every cycle
        done_d  = 1'b0;
        load_en = 1'b0;
        load_kp = (kind_q == MOTOR_BLDC) ? bldc_torque_kp : stepper_torque_kp;
        load_ti = (kind_q == MOTOR_BLDC) ? bldc_torque_ti : stepper_torque_ti;
        unique case (state_q)
            SETUP_IDLE: begin
                if (setup_start) begin
                    state_d = (autosrc_q == SRC_DETECT) ? SETUP_DETECT : SETUP_DONE;
                end
            end
            SETUP_DETECT: begin
                if (detect_done) begin
                    kind_d  = detected_bldc ? MOTOR_BLDC : MOTOR_STEPPER;
                    state_d = SETUP_LOAD;
                end
            end
            SETUP_LOAD: begin
                load_en = 1'b1;
                state_d = SETUP_DONE;
            end
            SETUP_DONE: begin
                done_d  = 1'b1;
                state_d = SETUP_IDLE;
            end
        endcase
        busy_d = (state_d != SETUP_IDLE);
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reserved_q  <= FLAG_RESET;
            field_ovr_q <= FLAG_RESET;
            autosrc_q   <= FLAG_RESET;
            split_q     <= FLAG_RESET;
            rdata_q     <= 32'h00000000;
            ack_q       <= 1'b0;
            err_q       <= 1'b0;
            state_q     <= SETUP_IDLE;
            kind_q      <= MOTOR_NONE;
            done_q      <= 1'b0;
            busy_q      <= 1'b0;
            split_params_q <= 1'b0;
        end else begin
            reserved_q  <= reserved_d;
            field_ovr_q <= field_ovr_d;
            autosrc_q   <= autosrc_d;
            split_q     <= split_d;
            rdata_q     <= rdata_d;
            ack_q       <= ack_d;
            err_q       <= err_d;
            state_q     <= state_d;
            kind_q      <= kind_d;
            done_q      <= done_d;
            busy_q      <= busy_d;
            split_params_q <= split_params_d;
        end
    end

    assign rdata        = rdata_q;
    assign ack          = ack_q;
    assign err          = err_q;
    assign split_params = split_params_q;
    assign setup_busy   = busy_q;
    assign setup_done   = done_q;
    assign motor_kind   = kind_q;
    assign torque_kp    = word_val[0];
    assign torque_ti    = word_val[1];
    assign flux_kp      = word_val[2];
    assign flux_ti      = word_val[3];
    assign vel_kp       = word_val[4];
    assign vel_ti       = word_val[5];
    assign pos_kp       = word_val[6];
    assign pos_ti       = word_val[7];
endmodule

/* File: design/param_store_pkg.sv */
// constants for the motor controller parameter store
package param_store_pkg;
    localparam logic [15:0] IDX_DRIVE_FLAGS = 16'h3212;
    localparam logic [15:0] IDX_CURRENT     = 16'h321A;
    localparam logic [15:0] IDX_VELOCITY    = 16'h321B;
    localparam logic [15:0] IDX_POSITION    = 16'h321C;

    localparam logic [7:0] SUB_COUNT    = 8'h00;
    localparam logic [7:0] SUB_RESERVED = 8'h01;
    localparam logic [7:0] SUB_FIELD    = 8'h02;
    localparam logic [7:0] SUB_AUTOSRC  = 8'h03;
    localparam logic [7:0] SUB_SPLIT    = 8'h04;
    localparam logic [7:0] SUB_ENTRY1   = 8'h01;
    localparam logic [7:0] SUB_ENTRY2   = 8'h02;
    localparam logic [7:0] SUB_ENTRY3   = 8'h03;
    localparam logic [7:0] SUB_ENTRY4   = 8'h04;

    localparam logic [7:0] DRIVE_FLAGS_COUNT = 8'h04;
    localparam logic [7:0] CURRENT_COUNT     = 8'h04;
    localparam logic [7:0] VELOCITY_COUNT    = 8'h02;
    localparam logic [7:0] POSITION_COUNT    = 8'h02;
    localparam logic [7:0] FLAG_RESET        = 8'h00;

    localparam logic [31:0] TORQUE_KP_RESET = 32'h000027E4;
    localparam logic [31:0] TORQUE_TI_RESET = 32'h00000446;
    localparam logic [31:0] FLUX_KP_RESET   = 32'h000027E4;
    localparam logic [31:0] FLUX_TI_RESET   = 32'h00000446;
    localparam logic [31:0] VEL_KP_RESET    = 32'h000000E0;
    localparam logic [31:0] VEL_TI_RESET    = 32'h0006ACFC;
    localparam logic [31:0] POS_KP_RESET    = 32'h00000032;
    localparam logic [31:0] POS_TI_RESET    = 32'h00000000;

    localparam logic [7:0] FIELD_DEFAULT = 8'h00;
    localparam logic [7:0] FIELD_NORMAL  = 8'h01;
    localparam logic [7:0] FIELD_INVERT  = 8'hFF;
    localparam logic [7:0] SRC_DETECT    = 8'h00;
    localparam logic [7:0] SRC_STORED    = 8'h01;

    // motor kind reported by detection
    typedef enum logic [1:0] {
        MOTOR_NONE    = 2'b00,
        MOTOR_STEPPER = 2'b01,
        MOTOR_BLDC    = 2'b10
    } motor_kind_t;

    typedef enum logic [1:0] {
        SETUP_IDLE   = 2'b00,
        SETUP_DETECT = 2'b01,
        SETUP_LOAD   = 2'b10,
        SETUP_DONE   = 2'b11
    } setup_state_t;
endpackage

/* File: design/param_word.sv */
// one 32-bit read/write parameter entry with preset and load path
`timescale 1ns/1ns
module param_word #(
    parameter logic [31:0] PRESET = 32'h00000000
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic        load_en,
    input  wire logic [31:0] load_data,
    output logic      [31:0] value
);
    logic [31:0] value_d;
    logic [31:0] value_q;

    // a bus write wins over a load arriving in the same cycle
    always_comb begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wr_data;
        end else if (load_en) begin
            value_d = load_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            value_q <= PRESET;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule

/* File: tb/dict_master.sv */
// fieldbus master model issuing single dictionary accesses
`timescale 1ns/1ns
module dict_master (
    input  wire logic        sys_clk,
    output logic             req,
    output logic             wr,
    output logic [15:0]      index,
    output logic [7:0]       subindex,
    output logic [31:0]      wdata,
    input  wire logic [31:0] rdata,
    input  wire logic        err
);
    initial {req, wr, index, subindex, wdata} = '0;
    // req is a one-cycle level: holding it would issue a second access
    task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        req      <= 1'b1;
        wr       <= w;
        index    <= i;
        subindex <= s;
        wdata    <= d;
        @(posedge sys_clk);
        req   <= 1'b0;
        wdata <= ~d;
        @(negedge sys_clk);
        r = rdata;
        e = err;
    endtask
endmodule

/* File: tb/motor_controller_param_store_bench.sv */
// self-checking bench for the motor controller parameter store
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", n, e, g); end end
module motor_controller_param_store_bench;
    import param_store_pkg::*;
    logic        sys_clk = 1'b0, nrst = 1'b0, restart = 1'b0, default_invert = 1'b0;
    logic        setup_start = 1'b0, detect_done = 1'b0, detected_bldc = 1'b0;
    logic        req, wr, ack, err, field_invert, split_params, setup_busy, setup_done;
    logic [1:0]  motor_kind;
    logic [7:0]  subindex;
    logic [7:0]  fv[4] = '{8'h01, 8'hFF, 8'h00, 8'h00};
    logic [15:0] index;
    logic [31:0] wdata, rdata, torque_kp, torque_ti, flux_kp, flux_ti, vel_kp, vel_ti, pos_kp, pos_ti;
    logic [31:0] stepper_torque_kp = 32'h0, stepper_torque_ti = 32'h0, bldc_torque_kp = 32'h0, bldc_torque_ti = 32'h0;
    logic [31:0] seed = 32'h142A35FA;
    int          failures = 0, checks = 0, cyc = 0, fexp = 0;
    int          ks[$];
    int          mdl[int] = '{32'h321200: 32'h4, 32'h321201: 32'h0, 32'h321202: 32'h0, 32'h321203: 32'h0,
        32'h321204: 32'h0, 32'h321A00: 32'h4, 32'h321A01: 32'h27E4, 32'h321A02: 32'h446, 32'h321A03: 32'h27E4,
        32'h321A04: 32'h446, 32'h321B00: 32'h2, 32'h321B01: 32'hE0, 32'h321B02: 32'h6ACFC, 32'h321C00: 32'h2,
        32'h321C01: 32'h32, 32'h321C02: 32'h0};
    motor_controller_param_store dut_u (.sys_clk, .nrst, .req, .wr, .index, .subindex, .wdata, .rdata, .ack, .err,
        .restart, .default_invert, .setup_start, .detect_done, .detected_bldc, .stepper_torque_kp,
        .stepper_torque_ti, .bldc_torque_kp, .bldc_torque_ti, .field_invert, .split_params, .setup_busy,
        .setup_done, .motor_kind, .torque_kp, .torque_ti, .flux_kp, .flux_ti, .vel_kp, .vel_ti, .pos_kp, .pos_ti);
    dict_master m_u (.sys_clk, .req, .wr, .index, .subindex, .wdata, .rdata, .err);
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task conclude();
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end
    // unmapped places are absent from the model, so err is expected exactly there
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        int          k;
        k = {i, s};
        m_u.access(w, i, s, d, r, e);
        `CHK("ack", 1, ack)
        `CHK("err", !mdl.exists(k), e)
        if (w && s != 8'h00 && mdl.exists(k)) mdl[k] = d;
        if (!w && mdl.exists(k)) `CHK("rdata", (i == IDX_DRIVE_FLAGS && s != 0) ? {{24{mdl[k][7]}}, mdl[k][7:0]} : mdl[k], r)
    endtask
    task automatic setup(input int mode);
        int t;
        t = 0;
        @(posedge sys_clk);
        setup_start <= 1'b1;
        @(posedge sys_clk);
        setup_start <= 1'b0;
        @(negedge sys_clk);
        `CHK("busy", 1, setup_busy)
        if (mode < 2) begin
            repeat (2) @(posedge sys_clk);
            detect_done   <= 1'b1;
            detected_bldc <= mode[0];
            @(posedge sys_clk);
            detect_done <= 1'b0;
            mdl[32'h321A01] = mode ? bldc_torque_kp : stepper_torque_kp;
            mdl[32'h321A02] = mode ? bldc_torque_ti : stepper_torque_ti;
            mdl[32'h321A03] = mdl[32'h321A01];
            mdl[32'h321A04] = mdl[32'h321A02];
        end
        while (setup_done !== 1'b1 && t < 20) begin
            @(negedge sys_clk);
            t++;
        end
        `CHK("setup_done", 1, setup_done)
        `CHK("idle", 0, setup_busy)
        `CHK("loop", {mdl[32'h321A01], mdl[32'h321A02], mdl[32'h321A03], mdl[32'h321A04]}, {torque_kp, torque_ti, flux_kp, flux_ti})
        if (mode < 2) `CHK("kind", mode + 1, motor_kind)
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst              <= 1'b1;
        stepper_torque_kp <= rnd();
        stepper_torque_ti <= rnd();
        bldc_torque_kp    <= rnd();
        bldc_torque_ti    <= rnd();
        foreach (mdl[k]) ks.push_back(k);
        foreach (ks[j]) acc(1'b0, ks[j][23:8], ks[j][7:0], 32'h0);
        acc(1'b0, IDX_VELOCITY, SUB_ENTRY3, 32'h0);
        acc(1'b1, 16'h321D, SUB_ENTRY1, rnd());
        foreach (ks[j]) acc(1'b1, ks[j][23:8], ks[j][7:0], rnd());
        acc(1'b1, IDX_CURRENT, SUB_ENTRY3, mdl[32'h321A01]);
        acc(1'b1, IDX_CURRENT, SUB_ENTRY4, mdl[32'h321A02]);
        `CHK("words", {mdl[32'h321A01], mdl[32'h321B02], mdl[32'h321C01]}, {torque_kp, vel_ti, pos_kp})
        for (int n = 0; n < 4; n++) begin
            acc(1'b1, IDX_DRIVE_FLAGS, SUB_FIELD, {24'hFFFFFF, fv[n]});
            `CHK("field_hold", fexp, field_invert)
            @(posedge sys_clk);
            restart        <= 1'b1;
            default_invert <= n[0];
            @(posedge sys_clk);
            restart <= 1'b0;
            repeat (2) @(negedge sys_clk);
            fexp = (fv[n] == 8'hFF) || (fv[n] == 8'h00 && n[0]);
            `CHK("field", fexp, field_invert)
        end
        foreach (fv[n]) begin
            acc(1'b1, IDX_DRIVE_FLAGS, SUB_SPLIT, {24'h0, fv[n]});
            `CHK("split", fv[n] != 8'h00, split_params)
        end
        acc(1'b1, IDX_DRIVE_FLAGS, SUB_AUTOSRC, 32'h0);
        setup(0);
        setup(1);
        acc(1'b1, IDX_DRIVE_FLAGS, SUB_AUTOSRC, 32'h1);
        setup(2);
        foreach (ks[j]) acc(1'b0, ks[j][23:8], ks[j][7:0], 32'h0);
        conclude();
    end
endmodule

/* File: tb/param_store_assertions.sv */
// port assertions for the motor controller parameter store
`timescale 1ns/1ns
module param_store_checker
    import param_store_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [15:0] index,
    input wire logic [7:0]  subindex,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        err,
    input wire logic        restart,
    input wire logic        field_invert,
    input wire logic        split_params,
    input wire logic [31:0] torque_kp,
    input wire logic [31:0] vel_kp,
    input wire logic [31:0] pos_ti
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence put(logic [15:0] i, logic [7:0] s);
        req && wr && index == i && subindex == s;
    endsequence
    chk_ack_follows: assert property (req |=> ack) else $error("no ack after request");
    chk_torque_write: assert property (put(IDX_CURRENT, SUB_ENTRY1) |=> torque_kp == $past(wdata))
        else $error("torque gain not written");
    chk_vel_write: assert property (put(IDX_VELOCITY, SUB_ENTRY1) |=> vel_kp == $past(wdata))
        else $error("velocity gain not written");
    chk_pos_write: assert property (put(IDX_POSITION, SUB_ENTRY2) |=> pos_ti == $past(wdata))
        else $error("position time not written");
    chk_count_read: assert property (req && !wr && index == IDX_VELOCITY && subindex == SUB_COUNT
        |=> rdata == {24'h0, VELOCITY_COUNT} && !err) else $error("count read wrong");
    chk_count_write: assert property (put(IDX_CURRENT, SUB_COUNT) |=> ack && !err)
        else $error("count write refused");
    chk_split_follows: assert property (put(IDX_DRIVE_FLAGS, SUB_SPLIT)
        |=> split_params == ($past(wdata[7:0]) != 8'h00)) else $error("split select wrong");
    // two quiet edges allow a two-stage restart path without a false alarm
    chk_field_hold: assert property (!restart && !$past(restart) |=> $stable(field_invert))
        else $error("field moved without restart");
endmodule
bind motor_controller_param_store param_store_checker chk_u (.sys_clk, .nrst, .req, .wr, .index, .subindex,
    .wdata, .rdata, .ack, .err, .restart, .field_invert, .split_params, .torque_kp, .vel_kp, .pos_ti);
